//--- include/ebi_pkg.sv
// Purpose: Shared types and constants for the external bus interface.
// Assumes: One 125 MHz clock; bus timing counted in clock cycles.
// Notes:   Configuration bits arrive as plain ports bundled in ebi_cfg_s.
package ebi_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Widths and clock
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int CLK_MHZ = 125;

    ////////////////////////////////////////////////////////////////////////
    // Bus type encodings of bus_mux_select
    localparam logic [1:0] MUX_NONE  = 2'h0;
    localparam logic [1:0] MUX_AREA2 = 2'h1;
    localparam logic [1:0] MUX_AREA1 = 2'h2;
    localparam logic [1:0] MUX_ALL   = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Address pin masks per width, shared-line masks per data width
    localparam logic [19:0] AMASK_12   = 20'h00FFF;
    localparam logic [19:0] AMASK_16   = 20'h0FFFF;
    localparam logic [19:0] AMASK_20   = 20'hFFFFF;
    localparam logic [19:0] SHARE_NARR = 20'h000FF;
    localparam logic [19:0] SHARE_WIDE = 20'h001FE;
    localparam logic [15:0] DMASK_NARR = 16'h00FF;
    localparam logic [15:0] DMASK_WIDE = 16'hFFFF;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [19:0] ADDR_RST = 20'h00000;
    localparam logic [2:0]  CNT_RST  = 3'h0;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ALE  = 2'b01,
        ST_STB  = 2'b10
    } ebi_state_e;

    typedef struct packed {
        logic       expand;
        logic       addr_mid_port_select;
        logic       addr_upper_disable;
        logic       strobe_scheme_select;
        logic       bank_mode;
        logic [1:0] bus_mux_select;
        logic [3:0] cs_enable;
        logic [3:0] area_wait_disable;
        logic [7:0] area_wait_count;
    } ebi_cfg_s;

    typedef struct packed {
        logic        ext;
        logic [1:0]  area;
        logic [3:0]  bank;
        logic [19:0] addr;
        logic        write;
        logic        word;
        logic [15:0] wdata;
    } ebi_req_s;

endpackage : ebi_pkg

//--- hw/ebi_strobe.sv
// Purpose: Encodes read, write and byte strobes for one bus cycle.
// Assumes: Inputs come from flip-flops on the same clock.
// Notes:   Pin o_wrl_n doubles as the single write strobe, o_wrh_n as
//          high_byte_enable_n, in the byte-enable scheme.
module ebi_strobe
    import ebi_pkg::*;
(
    // Cycle state
    input  wire logic       i_active,
    input  wire logic       i_write,
    input  wire logic [1:0] i_lanes,
    // Mode
    input  wire logic       i_narrow,
    input  wire logic       i_strobe_scheme_select,
    // Strobes
    output logic            o_rd_n,
    output logic            o_write_low_strobe_n,
    output logic            o_write_high_strobe_n
);

    wire split_w = !i_narrow && i_strobe_scheme_select;
    wire wr_w    = i_active && i_write;

    assign o_rd_n = !(i_active && !i_write);
    // Split scheme: one write strobe per byte lane
    assign o_write_low_strobe_n  = split_w ? !(wr_w && i_lanes[0])  // [R18] [R19]
                                           : !wr_w;                 // [R20] [R21]
    // Byte-enable scheme: high byte enable for reads and writes; unused narrow
    assign o_write_high_strobe_n = split_w  ? !(wr_w && i_lanes[1]) // [R19]
                                 : i_narrow ? 1'b1                  // [R21]
                                 : !(i_active && i_lanes[1]);       // [R20]

endmodule : ebi_strobe

//--- hw/ebi_core.sv
// Purpose: External bus master: separate and multiplexed address/data bus.
// Assumes: Area decode and internal/external choice done by the requester.
// Notes:   One request at a time; ready only in idle. Pins are split into
//          out, enable and in; inputs pass two flip-flops.
// Function
// R1: Narrow mux shares D0-D7 with A0-A7.
// R2: Wide mux shares D0-D7 with A1-A8.
// R3: Wide mux space: odd addresses not accessible.
// R4: Address width 12/16/20 from two bits.
// R5: Software uses only the three width encodings.
// R6: Address undefined until first external access.
// R7: Width pin high narrow, low wide.
// R8: Width pin held constant during operation.
// R9: Each chip select pin: port or select.
// R10: Four areas, or bank number output.
// R11: Ready or mux areas need wait states.
// R12: Internal wait needs area waits enabled.
// R13: Wait count from area_wait_count field.
// R14: Different area: address and select change.
// R15: Internal access: select drops, address holds.
// R16: Same area: select stays asserted.
// R17: No access: address and select hold.
// R18: Wide bus picks strobe scheme.
// R19: Split scheme encodes byte lanes by writes.
// R20: Byte-enable scheme uses high enable, A0.
// R21: Narrow bus: single strobe, enable unused.
// R22: Address latch strobe on mux cycles.
// R23: bus_mux_select picks multiplexed areas.
// R24: Address while latch high, then data.
module ebi_core
    import ebi_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // Configuration
    input  wire ebi_cfg_s    i_cfg,
    input  wire logic        i_byte_pin,
    // Request and answer
    input  wire logic        i_req_valid,
    input  wire ebi_req_s    i_req,
    output logic             o_req_ready,
    output logic             o_done,
    output logic             o_err,
    output logic [15:0]      o_rdata,
    // Address pins
    output logic [19:0]      o_a_out,
    output logic [19:0]      o_a_oe,
    input  wire logic [19:0] i_a_in,
    // Data pins
    output logic [15:0]      o_d_out,
    output logic [15:0]      o_d_oe,
    input  wire logic [15:0] i_d_in,
    // Control pins
    output logic [3:0]       o_cs_n,
    output logic [3:0]       o_cs_oe,
    output logic             o_rd_n,
    output logic             o_write_low_strobe_n,
    output logic             o_write_high_strobe_n,
    output logic             o_ale
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic is_mux(input logic [1:0] sel,
                                    input logic [1:0] area);
        is_mux = (sel == MUX_ALL)
              || (sel == MUX_AREA2 && area == 2'h2)
              || (sel == MUX_AREA1 && area == 2'h1);
    endfunction : is_mux

    function automatic logic [1:0] lanes_of(input logic narrow,
                                            input logic word,
                                            input logic a0);
        if (narrow)
            lanes_of = 2'h1;
        else if (a0)
            lanes_of = 2'h2;
        else
            lanes_of = word ? 2'h3 : 2'h1;
    endfunction : lanes_of

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic        byte_meta_reg;
    logic        byte_sync_reg;
    logic [19:0] a_meta_reg;
    logic [19:0] a_sync_reg;
    logic [15:0] d_meta_reg;
    logic [15:0] d_sync_reg;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            byte_meta_reg <= 1'b1;
            byte_sync_reg <= 1'b1;
            a_meta_reg    <= ADDR_RST;
            a_sync_reg    <= ADDR_RST;
            d_meta_reg    <= 16'h0000;
            d_sync_reg    <= 16'h0000;
        end else begin
            byte_meta_reg <= i_byte_pin;
            byte_sync_reg <= byte_meta_reg;
            a_meta_reg    <= i_a_in;
            a_sync_reg    <= a_meta_reg;
            d_meta_reg    <= i_d_in;
            d_sync_reg    <= d_meta_reg;
        end
    end

    // High level selects the narrow bus
    wire narrow_w = byte_sync_reg; // [R7]

    ////////////////////////////////////////////////////////////////////////
    // State
    ebi_state_e  state_reg;
    ebi_state_e  state_next;
    logic [19:0] addr_reg;
    logic [1:0]  area_reg;
    logic [3:0]  bank_reg;
    logic        cs_act_reg;
    logic [2:0]  cnt_reg;
    logic        wr_reg;
    logic [1:0]  lanes_reg;
    logic [15:0] wdata_reg;
    logic        mux_reg;
    logic        err_reg;
    logic        seen_reg;
    logic        done_reg;
    logic [15:0] rdata_reg;

    wire accept_w   = i_req_valid && (state_reg == ST_IDLE);
    wire acc_ext_w  = accept_w && i_req.ext;
    wire acc_int_w  = accept_w && !i_req.ext;
    wire req_mux_w  = is_mux(i_cfg.bus_mux_select, i_req.area); // [R23]
    wire req_err_w  = req_mux_w && !narrow_w && i_req.addr[0];  // [R3]
    wire last_w     = (state_reg == ST_STB) && (cnt_reg == CNT_RST);
    wire wait_dis_w = i_cfg.area_wait_disable[i_req.area];
    wire [1:0] wcnt_w = i_cfg.area_wait_count[{i_req.area, 1'b0} +: 2];
    // Wait states inserted only when waits are enabled for the area
    wire [2:0] waits_w = wait_dis_w ? CNT_RST : {1'b0, wcnt_w} + 3'h1; // [R13]

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (acc_ext_w)
                    state_next = req_mux_w ? ST_ALE : ST_STB;
            end
            ST_ALE: begin
                state_next = ST_STB;
            end
            ST_STB: begin
                if (cnt_reg == CNT_RST)
                    state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= CNT_RST;
        end else begin
            state_reg <= state_next;
            if (acc_ext_w)
                cnt_reg <= waits_w;
            else if (state_reg == ST_STB && cnt_reg != CNT_RST)
                cnt_reg <= cnt_reg - 3'h1;
        end
    end

    // Address and area update only on an external access; internal
    // accesses and idle cycles leave the address pins unchanged.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            addr_reg   <= ADDR_RST;
            area_reg   <= 2'h0;
            bank_reg   <= 4'h0;
            cs_act_reg <= 1'b0;
            seen_reg   <= 1'b0;
        end else if (acc_ext_w) begin // [R17]
            addr_reg   <= i_req.addr; // [R14] [R16]
            area_reg   <= i_req.area; // [R14]
            bank_reg   <= i_req.bank;
            cs_act_reg <= 1'b1;       // [R16]
            seen_reg   <= 1'b1;       // [R6]
        end else if (acc_int_w) begin
            cs_act_reg <= 1'b0;       // [R15]
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_reg    <= 1'b0;
            lanes_reg <= 2'h0;
            wdata_reg <= 16'h0000;
            mux_reg   <= 1'b0;
            err_reg   <= 1'b0;
        end else if (acc_ext_w) begin
            wr_reg    <= i_req.write;
            lanes_reg <= lanes_of(narrow_w, i_req.word, i_req.addr[0]);
            wdata_reg <= i_req.wdata;
            mux_reg   <= req_mux_w;
            err_reg   <= req_err_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read capture and answer
    wire [15:0] mux_rd_w = narrow_w ? {8'h00, a_sync_reg[7:0]}  // [R1]
                                    : {8'h00, a_sync_reg[8:1]}; // [R2]
    wire [15:0] sep_rd_w = narrow_w ? (d_sync_reg & DMASK_NARR)
                                    : d_sync_reg;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            done_reg  <= 1'b0;
            rdata_reg <= 16'h0000;
        end else begin
            done_reg <= last_w || acc_int_w;
            if (last_w && !wr_reg)
                rdata_reg <= mux_reg ? mux_rd_w : sep_rd_w;
        end
    end

    assign o_req_ready = (state_reg == ST_IDLE);
    assign o_done      = done_reg;
    assign o_err       = done_reg && err_reg;
    assign o_rdata     = rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Address pins
    wire stb_w       = (state_reg == ST_STB);
    wire mux_data_w  = mux_reg && stb_w;
    wire [19:0] share_w = narrow_w ? SHARE_NARR : SHARE_WIDE;
    wire [19:0] amask_w = !i_cfg.addr_upper_disable  ? AMASK_20   // [R4]
                        : i_cfg.addr_mid_port_select ? AMASK_12
                        : AMASK_16;
    wire [19:0] mux_wd_w = narrow_w ? {12'h000, wdata_reg[7:0]}
                                    : {11'h000, wdata_reg[7:0], 1'b0};

    // Shared lines carry address while the latch strobe is high, data after
    assign o_a_out = mux_data_w ? ((addr_reg & ~share_w) | mux_wd_w) // [R24] [R1] [R2]
                                : addr_reg;
    // Unused upper lines revert to ports; nothing driven before first access
    assign o_a_oe = (i_cfg.expand && seen_reg)                      // [R6]
                  ? (amask_w & ~((mux_data_w && !wr_reg) ? share_w : 20'h00000))
                  : 20'h00000;

    ////////////////////////////////////////////////////////////////////////
    // Data pins: D8-D15 on the narrow bus and all of D0-D15 on mux cycles stay undriven
    wire [15:0] dmask_w = narrow_w ? DMASK_NARR : DMASK_WIDE; // [R7]
    assign o_d_out = wdata_reg;
    assign o_d_oe  = (stb_w && wr_reg && !mux_reg) ? dmask_w : 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Chip selects and latch strobe
    wire [3:0] cs_sel_w = cs_act_reg ? (4'h1 << area_reg) : 4'h0;
    assign o_cs_n  = i_cfg.bank_mode ? bank_reg : ~cs_sel_w; // [R10] [R14]
    assign o_cs_oe = i_cfg.expand ? i_cfg.cs_enable : 4'h0;   // [R9]
    assign o_ale   = (state_reg == ST_ALE);                   // [R22]

    ebi_strobe u_strobe (
        .i_active               (stb_w && !err_reg), // [R3]
        .i_write                (wr_reg),
        .i_lanes                (lanes_reg),
        .i_narrow               (narrow_w),
        .i_strobe_scheme_select (i_cfg.strobe_scheme_select),
        .o_rd_n                 (o_rd_n),
        .o_write_low_strobe_n   (o_write_low_strobe_n),
        .o_write_high_strobe_n  (o_write_high_strobe_n)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_latch;
        o_ale && o_a_out == addr_reg;
    endsequence

    sequence s_data_phase;
        !o_ale && stb_w;
    endsequence

    ale_then_data_a: assert property ( // [R24]
        @(posedge i_clk) disable iff (i_rst)
        s_latch |=> s_data_phase)
        else $error("latch strobe not followed by data phase");

    ale_mux_only_a: assert property ( // [R23]
        @(posedge i_clk) disable iff (i_rst)
        acc_ext_w && !req_mux_w |=> !o_ale ##1 !o_ale)
        else $error("latch strobe on separate bus area");

    idle_hold_a: assert property ( // [R17]
        @(posedge i_clk) disable iff (i_rst)
        o_req_ready && !i_req_valid |=> $stable(o_a_out)
        && ($changed(i_cfg.bank_mode) || $stable(o_cs_n)))
        else $error("pins moved without an access");

    int_access_a: assert property ( // [R15]
        @(posedge i_clk) disable iff (i_rst)
        acc_int_w && !i_cfg.bank_mode |=> o_cs_n == 4'hF && $stable(addr_reg))
        else $error("internal access handling wrong");

    same_area_a: assert property ( // [R16]
        @(posedge i_clk) disable iff (i_rst)
        acc_ext_w && cs_act_reg && i_req.area == area_reg && !i_cfg.bank_mode
        |=> $stable(o_cs_n))
        else $error("select toggled within same area");

    no_wait_a: assert property ( // [R13]
        @(posedge i_clk) disable iff (i_rst)
        acc_ext_w && !req_mux_w && wait_dis_w |=> last_w ##1 o_done)
        else $error("no-wait cycle length wrong");

    narrow_bhe_a: assert property ( // [R21]
        @(posedge i_clk) disable iff (i_rst)
        narrow_w |-> o_write_high_strobe_n)
        else $error("byte enable active on narrow bus");

    odd_mux_a: assert property ( // [R3]
        @(posedge i_clk) disable iff (i_rst)
        stb_w && err_reg |-> o_rd_n && o_write_low_strobe_n)
        else $error("strobe on odd wide mux address");

    width_16_a: assert property ( // [R4]
        @(posedge i_clk) disable iff (i_rst)
        i_cfg.addr_upper_disable && !i_cfg.addr_mid_port_select
        |-> o_a_oe[19:16] == 4'h0)
        else $error("upper address lines driven");

    split_word_a: assert property ( // [R19]
        @(posedge i_clk) disable iff (i_rst)
        stb_w && wr_reg && !err_reg && !narrow_w && i_cfg.strobe_scheme_select
        && lanes_reg == 2'h3 |-> !o_write_low_strobe_n && !o_write_high_strobe_n)
        else $error("word write strobes wrong");

    mux_no_dpin_a: assert property ( // [R2]
        @(posedge i_clk) disable iff (i_rst)
        mux_reg && stb_w |-> o_d_oe == 16'h0000)
        else $error("data pins driven on a multiplexed cycle");

endmodule : ebi_core

//--- verif/ebi_mem_model.sv
// Purpose: Behavioural memory standing on the external parallel bus.
// Assumes: Strobes sampled on the bus clock; address taken while ale is high.
// Notes:   Released lines show the inverse of their last level.
module ebi_mem_model
    import ebi_pkg::*;
(
    // Clock
    input  wire logic        i_clk,
    // Bus pins from the device
    input  wire logic [19:0] i_a_out,
    input  wire logic [19:0] i_a_oe,
    input  wire logic [15:0] i_d_out,
    input  wire logic [15:0] i_d_oe,
    input  wire logic        i_rd_n,
    input  wire logic        i_wrl_n,
    input  wire logic        i_wrh_n,
    input  wire logic        i_ale,
    // Mode
    input  wire logic        i_narrow,
    input  wire logic        i_split,
    // Wire levels
    output logic [19:0]      o_a_in,
    output logic [15:0]      o_d_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0]  mem [0:511];
    logic [19:0] lat, alast, adrv;
    logic [15:0] dlast, ddrv;
    logic        mux = 1'b0;
    wire  [8:0]  adr = mux ? lat[8:0] : i_a_out[8:0];
    wire  [8:0]  ev  = {adr[8:1], 1'b0};
    wire         lo  = i_split ? !i_wrl_n : !adr[0];
    wire         hi  = !i_narrow & !i_wrh_n;
    wire         wr  = !i_wrl_n | (i_split & hi);
    wire  [15:0] dv  = !mux ? i_d_out : i_narrow ? {8'h00, i_a_out[7:0]} : {8'h00, i_a_out[8:1]};
    wire  [15:0] rv  = i_narrow ? {8'h00, mem[adr]} : {mem[ev | 9'h001], mem[ev]};
    initial begin
        for (int i = 0; i < 512; i++) begin
            mem[i] = 8'(i) ^ 8'h5A;
        end
    end
    always_comb begin
        adrv = ~alast;
        ddrv = ~dlast;
        if (!i_rd_n && !i_ale && !mux) begin
            ddrv = rv;
        end else if (!i_rd_n && !i_ale && i_narrow) begin
            adrv[7:0] = rv[7:0];
        end else if (!i_rd_n && !i_ale) begin
            adrv[8:1] = rv[7:0];
        end
    end
    assign o_a_in = (i_a_oe & i_a_out) | (~i_a_oe & adrv);
    assign o_d_in = (i_d_oe & i_d_out) | (~i_d_oe & ddrv);
    ////////////////////////////////////////////////////////////////////////
    // Address latch keeps the last value seen before ale falls
    always @(posedge i_clk) begin
        alast <= o_a_in;
        dlast <= o_d_in;
        if (i_ale) begin
            lat <= i_a_out;
        end
        mux <= i_ale | (mux & !(i_rd_n & i_wrl_n & i_wrh_n));
        if (wr && i_narrow) begin
            mem[adr] <= dv[7:0];
        end else if (wr) begin
            if (lo) begin
                mem[ev] <= dv[7:0];
            end
            if (hi) begin
                mem[ev | 9'h001] <= dv[15:8];
            end
        end
    end
endmodule : ebi_mem_model

//--- verif/external_bus_interface_bench.sv
// Purpose: Self-checking bench for the external bus master.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Strobe-time pin values are snapshotted by a monitor.
module external_bus_interface_bench;
    import ebi_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk      = 1'b0;
    logic        rst      = 1'b1;
    logic        byte_pin = 1'b0;
    logic        vld      = 1'b0;
    ebi_cfg_s    cfg      = '0;
    ebi_req_s    req      = '0;
    logic        rdy, done, err, rd_n, wrl_n, wrh_n, ale;
    logic [15:0] rdata, d_out, d_oe, d_in, lrd;
    logic [19:0] a_out, a_oe, a_in, la, sa, soe;
    logic [3:0]  cs_n, cs_oe, scs;
    logic [2:0]  sstb;
    logic        ale_seen, stb_seen, cs_up, lerr;
    int          n_fail  = 0;
    int          checked = 0;
    int          n;
    always #4 clk = ~clk;
    ebi_core DUT (.i_clk(clk), .i_rst(rst), .i_cfg(cfg), .i_byte_pin(byte_pin),
        .i_req_valid(vld), .i_req(req), .o_req_ready(rdy), .o_done(done), .o_err(err),
        .o_rdata(rdata), .o_a_out(a_out), .o_a_oe(a_oe), .i_a_in(a_in), .o_d_out(d_out),
        .o_d_oe(d_oe), .i_d_in(d_in), .o_cs_n(cs_n), .o_cs_oe(cs_oe), .o_rd_n(rd_n),
        .o_write_low_strobe_n(wrl_n), .o_write_high_strobe_n(wrh_n), .o_ale(ale));
    ebi_mem_model mem (.i_clk(clk), .i_a_out(a_out), .i_a_oe(a_oe), .i_d_out(d_out),
        .i_d_oe(d_oe), .i_rd_n(rd_n), .i_wrl_n(wrl_n), .i_wrh_n(wrh_n), .i_ale(ale),
        .i_narrow(byte_pin), .i_split(cfg.strobe_scheme_select), .o_a_in(a_in),
        .o_d_in(d_in));
    always @(posedge clk) begin
        if (ale) begin
            ale_seen <= 1'b1;
            la <= a_out;
        end
        if (!(rd_n & wrl_n & wrh_n)) begin
            stb_seen <= 1'b1;
            sa <= a_out;
            soe <= a_oe;
            scs <= cs_n;
            sstb <= {rd_n, wrl_n, wrh_n};
        end
        if (cs_n[0]) begin
            cs_up <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    function automatic int exp_lat(input int ar);
        return 2 + (cfg.area_wait_disable[ar] ? 0 : int'(cfg.area_wait_count[2*ar +: 2]) + 1);
    endfunction : exp_lat
    task automatic do_reset(input logic bp);
        rst = 1'b1;
        byte_pin = bp;
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask : do_reset
    // One request, answer counted in edges from the accepting edge, that edge included
    task automatic acc(input logic ex, input logic [1:0] ar, input logic [19:0] ad,
                       input logic wr, input logic wd, input logic [15:0] dt);
        int k;
        ale_seen = 1'b0;
        stb_seen = 1'b0;
        cs_up = 1'b0;
        req = '{ex, ar, 4'h6, ad, wr, wd, dt};
        vld = 1'b1;
        for (k = 0; k < 50 && rdy !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1 vld = 1'b0;
        for (n = 1; n < 50 && done !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        lerr = err;
        lrd = rdata;
        if (k == 50 || n == 50) begin
            n_fail++;
            end_sim();
        end
    endtask : acc
    ////////////////////////////////////////////////////////////////////////
    task automatic t_width;
        logic [19:0] m;
        chk("a_oe", a_oe, 20'h00000);
        acc(0, 0, 20'h00300, 0, 1, 16'h0000);
        chk("a_oe", a_oe, 20'h00000);
        for (int i = 0; i < 3; i++) begin
            cfg.addr_mid_port_select = (i == 0);
            cfg.addr_upper_disable = (i != 2);
            m = i == 0 ? AMASK_12 : i == 1 ? AMASK_16 : AMASK_20;
            acc(1, 0, 20'hABCDE, 1, 1, 16'h0000);
            chk("a_oe", soe, m);
            chk("a_out", sa & m, 20'hABCDE & m);
        end
    endtask : t_width
    task automatic t_split;
        cfg.strobe_scheme_select = 1'b1;
        acc(1, 0, 20'h00010, 1, 1, 16'h1234);
        chk("stb", sstb, 3'b100);
        acc(1, 0, 20'h00013, 1, 0, 16'hAB00);
        chk("stb", sstb, 3'b110);
        acc(1, 0, 20'h00014, 1, 0, 16'h0056);
        chk("stb", sstb, 3'b101);
        acc(1, 0, 20'h00012, 0, 1, 16'h0000);
        chk("rd", lrd, 16'hAB48);
        for (int ar = 0; ar < 4; ar++) begin
            acc(1, 2'(ar), 20'h00010, 0, 1, 16'h0000);
            chk("lat", 20'(n), 20'(exp_lat(ar)));
            chk("rd", lrd, 16'h1234);
        end
        chk("stb", sstb, 3'b011);
        cfg.area_wait_disable = 4'h8;
        acc(1, 3, 20'h00016, 1, 1, 16'h0000);
        chk("lat", 20'(n), 20'd2);
        cfg.area_wait_disable = 4'h0;
    endtask : t_split
    task automatic t_be;
        cfg.strobe_scheme_select = 1'b0;
        acc(1, 0, 20'h00021, 1, 0, 16'hCD00);
        chk("stb_a0", {sstb, sa[0]}, 4'b1001);
        acc(1, 0, 20'h00020, 1, 0, 16'h00EF);
        chk("stb_a0", {sstb, sa[0]}, 4'b1010);
        acc(1, 0, 20'h00020, 0, 1, 16'h0000);
        chk("stb_a0", {sstb, sa[0]}, 4'b0100);
        chk("rd", lrd, 16'hCDEF);
    endtask : t_be
    task automatic t_cs;
        acc(1, 0, 20'h00100, 0, 1, 16'h0000);
        @(posedge clk);
        #1 chk("cs", cs_n, 4'hE);
        chk("a", a_out, 20'h00100);
        acc(1, 0, 20'h00102, 0, 1, 16'h0000);
        chk("cs_up", cs_up, 1'b0);
        chk("a", a_out, 20'h00102);
        acc(1, 2, 20'h00200, 0, 1, 16'h0000);
        chk("cs", scs, 4'hB);
        chk("a", sa, 20'h00200);
        acc(0, 2, 20'h00300, 0, 1, 16'h0000);
        chk("cs", cs_n, 4'hF);
        chk("a", a_out, 20'h00200);
        cfg.cs_enable = 4'h5;
        @(posedge clk);
        #1 chk("cs_oe", cs_oe, 4'h5);
        cfg.cs_enable = 4'hF;
        cfg.bank_mode = 1'b1;
        acc(1, 1, 20'h00010, 0, 1, 16'h0000);
        chk("bank", scs, 4'h6);
        cfg.bank_mode = 1'b0;
    endtask : t_cs
    task automatic t_mux;
        logic mx;
        for (int c = 0; c < 4; c++) begin
            cfg.bus_mux_select = 2'(c);
            for (int ar = 1; ar < 3; ar++) begin
                mx = (c == 3) || (c == 1 && ar == 2) || (c == 2 && ar == 1);
                acc(1, 2'(ar), 20'h00040, 1, 0, 16'h0077);
                chk("ale", ale_seen, mx);
                chk("lat", 20'(n), 20'(exp_lat(ar) + int'(mx)));
                if (mx) begin
                    chk("adr", la[8:1], 8'h20);
                    chk("dat", sa[8:1], 8'h77);
                end
            end
        end
        acc(1, 1, 20'h00040, 0, 0, 16'h0000);
        chk("rd", lrd[7:0], 8'h77);
        acc(1, 1, 20'h00041, 0, 0, 16'h0000);
        chk("err", lerr, 1'b1);
        chk("stb", stb_seen, 1'b0);
        cfg.bus_mux_select = MUX_NONE;
    endtask : t_mux
    task automatic t_narrow;
        do_reset(1'b1);
        acc(1, 0, 20'h00031, 1, 0, 16'h0099);
        chk("stb", sstb[2:1], 2'b10);
        acc(1, 0, 20'h00031, 0, 0, 16'h0000);
        chk("rd", lrd[7:0], 8'h99);
        cfg.bus_mux_select = MUX_ALL;
        acc(1, 0, 20'h00033, 1, 0, 16'h0044);
        chk("adr", la[7:0], 8'h33);
        chk("dat", sa[7:0], 8'h44);
        acc(1, 0, 20'h00033, 0, 0, 16'h0000);
        chk("rd", lrd[7:0], 8'h44);
    endtask : t_narrow
    initial begin
        cfg.expand = 1'b1;
        cfg.cs_enable = 4'hF;
        cfg.area_wait_count = 8'hD9;
        do_reset(1'b0);
        t_width();
        t_split();
        t_be();
        t_cs();
        t_mux();
        t_narrow();
        end_sim();
    end
endmodule : external_bus_interface_bench
